/* src/icache_pkg.sv */
package icache_pkg;

    localparam int WORD_W     = 32;
    localparam int NUM_WAYS   = 32;
    localparam int NUM_SETS   = 32;
    localparam int LINE_WORDS = 8;
    localparam int NUM_FBUF   = 2;
    localparam int SET_LSB    = 5;
    localparam int TAG_LSB    = 10;
    localparam int WORD_LSB   = 2;
    localparam int TAG_W      = 22;
    localparam int LINE_W     = 27;
    localparam int RAM_AW     = 13;
    localparam int RAM_DW     = 33;

    localparam logic [4:0] RR_RESET   = 5'h1f;
    localparam logic [4:0] LOCK_LIMIT = 5'h1c;
    localparam logic [4:0] LOCK_RESET = 5'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_ARR, ST_WAIT} req_state_t;
    typedef enum logic [1:0] {FB_IDLE, FB_FILL, FB_WRITE} fbuf_state_t;

endpackage : icache_pkg

/* src/icache_ram.sv */
`timescale 1ns/100ps
module icache_ram #(
    parameter int DW = 33,
    parameter int AW = 13
) (
    input  wire logic          clk,    // core clock
    input  wire logic          we,     // write strobe
    input  wire logic [AW-1:0] waddr,  // write address
    input  wire logic [DW-1:0] wdata,  // write data
    input  wire logic [AW-1:0] raddr,  // read address
    output logic      [DW-1:0] rdata   // registered read data
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : icache_ram

/* src/icache_fetch.sv */
//
// Function
// - 32 KB, 32 ways, 8-word lines
// - index and tag by remapped virtual address
// - lookup every request, return hits directly
// - miss fetches the whole eight-word line
// - cacheable if MMU off or page C set
// - fetch buffer hit answers like cache hit
// - disabled: no allocation, hits still served
// - two fetch buffers stay active when disabled
// - two outstanding misses, one buffer each
// - allocate buffer, then one line request
// - words any order, set word valid
// - forward requested word on arrival
// - full line written if cacheable and enabled
// - clear buffer valid bits after writing
// - per-set round-robin pointer, others untouched
// - pointer resets to 31, wraps past locks
// - one parity bit per word, tags none
// - abort only when executed, record fault in the same cycle
// - no snooping of program memory writes
// - lock lines singly, skip them in replacement
// - at most 28 locked ways, else ignore lock
// - reset: disabled, unlocked, all invalid
// - enable comes from control bit 12
// - invalidate keeps locked lines, clears buffers
//
`timescale 1ns/100ps
module icache_fetch
    import icache_pkg::*;
(
    input  wire logic        CLK,            // core clock
    input  wire logic        RSTN,           // async reset, low
    input  wire logic        CACHE_EN,       // control bit 12
    input  wire logic        MMU_EN,         // translation on
    input  wire logic        INV_ALL,        // global invalidate
    input  wire logic        UNLOCK_ALL,     // global unlock
    input  wire logic        REQ_VALID,      // fetch request
    input  wire logic [31:0] REQ_ADDR,       // remapped virtual addr
    input  wire logic        REQ_CACHEABLE,  // page C bit
    input  wire logic        REQ_LOCK,       // fill and lock line
    output logic             REQ_READY,      // request taken
    output logic             RSP_VALID,      // instruction valid
    output logic [31:0]      RSP_INSTR,      // instruction word
    output logic             RSP_PERR,       // word parity bad
    input  wire logic        EXEC_PERR,      // bad word executed
    input  wire logic        FSR_CLR,        // clear fault record
    output logic             PREFETCH_ABORT, // abort pulse
    output logic             FSR_PERR,       // fault status record
    output logic             BUS_REQ,        // line request
    output logic [31:0]      BUS_ADDR,       // line aligned addr
    output logic [2:0]       BUS_CRIT,       // critical word
    output logic             BUS_ID,         // target buffer
    input  wire logic        BUS_ACK,        // request accepted
    input  wire logic        BUS_RVALID,     // returned word
    input  wire logic        BUS_RID,        // its buffer
    input  wire logic [2:0]  BUS_RIDX,       // its word index
    input  wire logic [31:0] BUS_RDATA       // its data
);

    // ************************************************************
    // address fields
    // ************************************************************
    function automatic logic [4:0] set_of(input logic [31:0] a);
        return a[SET_LSB +: 5];
    endfunction : set_of

    function automatic logic [2:0] word_of(input logic [31:0] a);
        return a[WORD_LSB +: 3];
    endfunction : word_of

    function automatic logic [LINE_W-1:0] line_of(input logic [31:0] a);
        return a[31:SET_LSB];
    endfunction : line_of

    function automatic logic [NUM_WAYS-1:0] lock_mask(
        input logic [4:0] n);
        logic [NUM_WAYS-1:0] m;
        m = '0;
        for (int w = 0; w < NUM_WAYS; w++) begin
            m[w] = 5'(w) < n;
        end
        return m;
    endfunction : lock_mask

    // ************************************************************
    // state
    // ************************************************************
    logic [TAG_W-1:0]     tag_mem  [NUM_SETS*NUM_WAYS];
    logic [NUM_WAYS-1:0]  vld_reg  [NUM_SETS];
    logic [4:0]           rr_reg   [NUM_SETS];
    logic [4:0]           lk_reg   [NUM_SETS];
    fbuf_state_t          fb_st_reg   [NUM_FBUF];
    logic [LINE_W-1:0]    fb_line_reg [NUM_FBUF];
    logic [7:0]           fb_wv_reg   [NUM_FBUF];
    logic [3:0]           fb_cnt_reg  [NUM_FBUF];
    logic                 fb_cach_reg [NUM_FBUF];
    logic                 fb_lock_reg [NUM_FBUF];
    logic                 fb_drop_reg [NUM_FBUF];
    logic [WORD_W-1:0]    fb_data [NUM_FBUF][LINE_WORDS];
    req_state_t           state_reg;
    logic [31:0]          pend_addr_reg;
    logic                 pend_cach_reg;
    logic                 pend_lock_reg;
    logic                 fe_busy_reg;
    logic                 fe_buf_reg;
    logic [2:0]           fe_cnt_reg;
    logic [4:0]           fe_way_reg;
    logic [RAM_DW-1:0]    ram_rdata;

    // ************************************************************
    // array lookup on the incoming request
    // ************************************************************
    wire  [4:0]       req_set = set_of(REQ_ADDR);
    wire  [TAG_W-1:0] req_tag = REQ_ADDR[31:TAG_LSB];
    logic             hit_any;
    logic [4:0]       hit_way;

    always_comb begin
        hit_any = 1'b0;
        hit_way = '0;
        for (int w = 0; w < NUM_WAYS; w++) begin
            if (vld_reg[req_set][w] &&
                tag_mem[{req_set, 5'(w)}] == req_tag) begin
                hit_any = 1'b1;
                hit_way = 5'(w);
            end
        end
    end

    wire req_take = state_reg == ST_IDLE && REQ_VALID;
    // lookup works whether or not the cache is enabled
    wire arr_hit  = hit_any && !REQ_LOCK;

    // ************************************************************
    // fetch buffer match and allocation
    // ************************************************************
    logic [NUM_FBUF-1:0] fb_match;
    logic [NUM_FBUF-1:0] fb_free;
    logic [NUM_FBUF-1:0] fill_done;

    for (genvar b = 0; b < NUM_FBUF; b++) begin : g_fb
        assign fb_match[b] = !fb_drop_reg[b] &&
            fb_line_reg[b] == line_of(pend_addr_reg) &&
            (fb_st_reg[b] == FB_FILL || |fb_wv_reg[b]);
        assign fb_free[b]  = fb_st_reg[b] == FB_IDLE;
        // last word of this buffer's line arrives now
        assign fill_done[b] = BUS_RVALID && BUS_RID == 1'(b) &&
                              fb_cnt_reg[b] == 4'h7;
    end

    wire [2:0] wd        = word_of(pend_addr_reg);
    wire       any_match = |fb_match;
    wire       match_id  = fb_match[1];
    wire       word_ok   = any_match && fb_wv_reg[match_id][wd];
    wire       alloc_ok  = state_reg == ST_WAIT && !BUS_REQ &&
                           (pend_lock_reg || !any_match) &&
                           |fb_free && !INV_ALL;
    wire       alloc_id  = !fb_free[0] ? 1'b1 :
                           !fb_free[1] ? 1'b0 : |fb_wv_reg[0];

    // ************************************************************
    // line writer: victim choice and pointers
    // ************************************************************
    wire        fe_sel   = fb_st_reg[0] != FB_WRITE;
    wire        fe_start = !fe_busy_reg && !INV_ALL &&
        (fb_st_reg[0] == FB_WRITE || fb_st_reg[1] == FB_WRITE);
    wire [4:0]  st_set   = fb_line_reg[fe_sel][4:0];
    wire [4:0]  st_rr    = rr_reg[st_set];
    wire [4:0]  st_lk    = lk_reg[st_set];
    wire        do_lock  = fb_lock_reg[fe_sel] && st_lk < LOCK_LIMIT;
    wire [4:0]  st_way   = do_lock ? st_lk : st_rr;
    wire [4:0]  fe_set   = fb_line_reg[fe_buf_reg][4:0];
    wire        fe_last  = fe_busy_reg && fe_cnt_reg == 3'h7;
    wire [31:0] fe_word  = fb_data[fe_buf_reg][fe_cnt_reg];

    // ************************************************************
    // tag array, lock counts, round-robin pointers, valid bits
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (fe_start) begin
            tag_mem[{st_set, st_way}] <=
                fb_line_reg[fe_sel][LINE_W-1:5];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int s = 0; s < NUM_SETS; s++) begin
                vld_reg[s] <= '0;
                rr_reg[s]  <= RR_RESET;
                lk_reg[s]  <= LOCK_RESET;
            end
        end else begin
            if (fe_start) begin
                vld_reg[st_set][st_way] <= 1'b0;
                if (do_lock) begin
                    lk_reg[st_set] <= st_lk + 5'h01;
                    rr_reg[st_set] <= RR_RESET;
                end else if (fb_lock_reg[fe_sel]) begin
                    rr_reg[st_set] <= RR_RESET;
                end else if (st_rr == RR_RESET) begin
                    rr_reg[st_set] <= st_lk;
                end else begin
                    rr_reg[st_set] <= st_rr + 5'h01;
                end
            end
            if (fe_last) begin
                vld_reg[fe_set][fe_way_reg] <= 1'b1;
            end
            // besides victim replacement, only this invalidate drops lines: writes are not snooped
            if (INV_ALL) begin
                for (int s = 0; s < NUM_SETS; s++) begin
                    vld_reg[s] <= vld_reg[s] &
                                  lock_mask(lk_reg[s]);
                end
            end
            if (UNLOCK_ALL) begin
                for (int s = 0; s < NUM_SETS; s++) begin
                    lk_reg[s] <= LOCK_RESET;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fe_busy_reg <= 1'b0;
            fe_buf_reg  <= 1'b0;
            fe_cnt_reg  <= '0;
            fe_way_reg  <= '0;
        end else if (INV_ALL) begin
            fe_busy_reg <= 1'b0;
        end else if (fe_start) begin
            fe_busy_reg <= 1'b1;
            fe_buf_reg  <= fe_sel;
            fe_cnt_reg  <= '0;
            fe_way_reg  <= st_way;
        end else if (fe_busy_reg) begin
            fe_cnt_reg  <= fe_cnt_reg + 3'h1;
            fe_busy_reg <= !fe_last;
        end
    end

    icache_ram #(
        .DW (RAM_DW),
        .AW (RAM_AW)
    ) u_ram (
        .clk   (CLK),
        .we    (fe_busy_reg && !INV_ALL),
        .waddr ({fe_set, fe_way_reg, fe_cnt_reg}),
        .wdata ({^fe_word, fe_word}),
        .raddr ({req_set, hit_way, word_of(REQ_ADDR)}),
        .rdata (ram_rdata)
    );

    // ************************************************************
    // fetch buffers
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (BUS_RVALID && fb_st_reg[BUS_RID] == FB_FILL) begin
            fb_data[BUS_RID][BUS_RIDX] <= BUS_RDATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int b = 0; b < NUM_FBUF; b++) begin
                fb_st_reg[b]   <= FB_IDLE;
                fb_line_reg[b] <= '0;
                fb_wv_reg[b]   <= '0;
                fb_cnt_reg[b]  <= '0;
                fb_cach_reg[b] <= 1'b0;
                fb_lock_reg[b] <= 1'b0;
                fb_drop_reg[b] <= 1'b0;
            end
        end else begin
            if (alloc_ok) begin
                fb_st_reg[alloc_id]   <= FB_FILL;
                fb_line_reg[alloc_id] <= line_of(pend_addr_reg);
                fb_wv_reg[alloc_id]   <= '0;
                fb_cnt_reg[alloc_id]  <= '0;
                fb_cach_reg[alloc_id] <= pend_cach_reg;
                fb_lock_reg[alloc_id] <= pend_lock_reg;
                fb_drop_reg[alloc_id] <= 1'b0;
            end
            if (BUS_RVALID && fb_st_reg[BUS_RID] == FB_FILL) begin
                fb_cnt_reg[BUS_RID] <= fb_cnt_reg[BUS_RID] + 4'h1;
                if (!fb_drop_reg[BUS_RID]) begin
                    fb_wv_reg[BUS_RID][BUS_RIDX] <= 1'b1;
                end
                if (fb_cnt_reg[BUS_RID] == 4'h7) begin
                    fb_drop_reg[BUS_RID] <= 1'b0;
                    fb_st_reg[BUS_RID] <= (!fb_drop_reg[BUS_RID] &&
                        fb_cach_reg[BUS_RID] && CACHE_EN) ?
                        FB_WRITE : FB_IDLE;
                end
            end
            if (fe_last) begin
                fb_st_reg[fe_buf_reg] <= FB_IDLE;
                fb_wv_reg[fe_buf_reg] <= '0;
            end
            if (INV_ALL) begin
                for (int b = 0; b < NUM_FBUF; b++) begin
                    fb_wv_reg[b] <= '0;
                    // a fill ending in this cycle is discarded outright
                    if (fb_st_reg[b] == FB_FILL && !fill_done[b]) begin
                        fb_drop_reg[b] <= 1'b1;
                    end else begin
                        fb_st_reg[b] <= FB_IDLE;
                    end
                end
            end
        end
    end

    // ************************************************************
    // request sequencing, answers and line requests
    // ************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg     <= ST_IDLE;
            REQ_READY     <= 1'b0;
            pend_addr_reg <= '0;
            pend_cach_reg <= 1'b0;
            pend_lock_reg <= 1'b0;
            RSP_VALID     <= 1'b0;
            RSP_INSTR     <= '0;
            RSP_PERR      <= 1'b0;
            BUS_REQ       <= 1'b0;
            BUS_ADDR      <= '0;
            BUS_CRIT      <= '0;
            BUS_ID        <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            REQ_READY <= 1'b0;
            if (BUS_ACK) begin
                BUS_REQ <= 1'b0;
            end
            unique case (state_reg)
                ST_IDLE: begin
                    REQ_READY <= !REQ_VALID;
                    if (req_take) begin
                        pend_addr_reg <= REQ_ADDR;
                        pend_cach_reg <= !MMU_EN ||
                                         REQ_CACHEABLE;
                        pend_lock_reg <= REQ_LOCK;
                        state_reg <= arr_hit ? ST_ARR : ST_WAIT;
                    end
                end
                ST_ARR: begin
                    RSP_VALID <= 1'b1;
                    RSP_INSTR <= ram_rdata[WORD_W-1:0];
                    RSP_PERR  <= ^ram_rdata;
                    REQ_READY <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_WAIT: begin
                    if (alloc_ok) begin
                        BUS_REQ  <= 1'b1;
                        BUS_ADDR <= {line_of(pend_addr_reg),
                                     5'h00};
                        BUS_CRIT <= wd;
                        BUS_ID   <= alloc_id;
                    end
                    if (pend_lock_reg ? alloc_ok : word_ok) begin
                        RSP_VALID <= !pend_lock_reg;
                        RSP_INSTR <= fb_data[match_id][wd];
                        RSP_PERR  <= 1'b0;  // buffer words carry no parity
                        REQ_READY <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // parity fault record and abort
    // ************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PREFETCH_ABORT <= 1'b0;
            FSR_PERR       <= 1'b0;
        end else begin
            PREFETCH_ABORT <= EXEC_PERR;
            FSR_PERR       <= EXEC_PERR ||
                              (FSR_PERR && !FSR_CLR);
        end
    end

endmodule : icache_fetch

/* test/icache_fetch_properties.sv */
`timescale 1ns/100ps
module icache_fetch_properties (
    input wire logic        CLK,            // core clock
    input wire logic        RSTN,           // reset, low
    input wire logic        REQ_VALID,      // fetch request
    input wire logic        REQ_LOCK,       // lock request
    input wire logic        REQ_READY,      // idle
    input wire logic        RSP_VALID,      // answer
    input wire logic        EXEC_PERR,      // bad word run
    input wire logic        FSR_CLR,        // clear record
    input wire logic        PREFETCH_ABORT, // abort
    input wire logic        FSR_PERR,       // fault record
    input wire logic        BUS_REQ,        // line request
    input wire logic [31:0] BUS_ADDR,       // line address
    input wire logic [2:0]  BUS_CRIT,       // critical word
    input wire logic        BUS_ID,         // buffer
    input wire logic        BUS_ACK,        // accepted
    input wire logic        BUS_RVALID      // word strobe
);
    // ********
    // lines in flight on the bus
    // ********
    logic [1:0] open_reg, open_next;
    logic [2:0] word_reg;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            open_reg <= 2'h0;
            word_reg <= 3'h0;
        end else begin
            open_reg <= open_next;
            word_reg <= word_reg + {2'h0, BUS_RVALID};
        end
    end
    assign open_next = open_reg + {1'b0, BUS_REQ & BUS_ACK}
                     - {1'b0, BUS_RVALID && word_reg == 3'h7};

    // ********
    // properties
    // ********
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence take_s;
        REQ_VALID && REQ_READY && !REQ_LOCK;
    endsequence
    sequence held_s;
        BUS_REQ && $stable(BUS_ADDR) && $stable(BUS_CRIT) && $stable(BUS_ID);
    endsequence
    req_hold_a: assert property (BUS_REQ && !BUS_ACK |=> held_s)
        else $error("line request changed before ack");
    line_align_a: assert property (BUS_REQ |-> BUS_ADDR[4:0] == 5'h00)
        else $error("line address not aligned");
    rsp_bound_a: assert property (take_s |-> ##[2:80] RSP_VALID)
        else $error("request not answered");
    rsp_early_a: assert property (take_s |=> !RSP_VALID)
        else $error("answer before lookup");
    miss_open_a: assert property (open_reg <= 2'h2)
        else $error("more than two lines outstanding");
    abort_cause_a: assert property (
        EXEC_PERR |=> PREFETCH_ABORT && FSR_PERR)
        else $error("executed bad word not aborted");
    abort_only_a: assert property (
        PREFETCH_ABORT |-> $past(EXEC_PERR))
        else $error("abort without cause");
    fsr_clear_a: assert property (FSR_CLR && !EXEC_PERR |=> !FSR_PERR)
        else $error("fault record not cleared");
    fsr_hold_a: assert property (FSR_PERR && !FSR_CLR |=> FSR_PERR)
        else $error("fault record lost");
    reset_quiet_a: assert property (
        $rose(RSTN) |-> !BUS_REQ && !RSP_VALID)
        else $error("activity right after reset");
endmodule : icache_fetch_properties

bind icache_fetch icache_fetch_properties chk (
    .CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_LOCK(REQ_LOCK),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .EXEC_PERR(EXEC_PERR),
    .FSR_CLR(FSR_CLR), .PREFETCH_ABORT(PREFETCH_ABORT),
    .FSR_PERR(FSR_PERR), .BUS_REQ(BUS_REQ), .BUS_ADDR(BUS_ADDR),
    .BUS_CRIT(BUS_CRIT), .BUS_ID(BUS_ID), .BUS_ACK(BUS_ACK),
    .BUS_RVALID(BUS_RVALID)
);

/* test/mem_model.sv */
`timescale 1ns/100ps
module mem_model (
    input  wire logic        clk,      // core clock
    input  wire logic        rstn,     // reset, low
    input  wire logic [3:0]  gap,      // idle cycles per step
    input  wire logic        bus_req,  // line request
    input  wire logic [31:0] bus_addr, // line address
    input  wire logic [2:0]  bus_crit, // critical word
    input  wire logic        bus_id,   // buffer
    output logic             ack,      // request accepted
    output logic             rvalid,   // word strobe
    output logic             rid,      // word buffer
    output logic [2:0]       ridx,     // word index
    output logic [31:0]      rdata     // word data
);
    // ********
    // one line at a time, critical word first
    // ********
    logic [31:0] a;
    logic [2:0]  c;
    logic        b;
    initial begin
        {ack, rvalid, rid, ridx, rdata} = '0;
        forever begin
            @(negedge clk);
            if (rstn && bus_req) begin
                a = bus_addr;
                c = bus_crit;
                b = bus_id;
                repeat (gap) @(negedge clk);
                ack = 1'b1;
                @(negedge clk);
                ack = 1'b0;
                for (int i = 0; i < 8; i++) begin
                    repeat (gap) begin
                        rvalid = 1'b0;
                        rdata = ~rdata;
                        @(negedge clk);
                    end
                    rvalid = 1'b1;
                    rid = b;
                    ridx = c + i[2:0];
                    rdata = ~{a[31:5], ridx, 2'b00};
                    @(negedge clk);
                end
                rvalid = 1'b0;
                rdata = ~rdata;
            end
        end
    end
endmodule : mem_model

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
    // ********
    // stimulus and checks
    // ********
    logic        clk = 1'b0, rstn = 1'b0, cen = 1'b0, mmu = 1'b0;
    logic        inv = 1'b0, unl = 1'b0, rv = 1'b0, rc = 1'b0;
    logic        rl = 1'b0, ep = 1'b0, fc = 1'b0;
    logic [31:0] ra = 32'h0;
    logic [3:0]  gap = 4'h0;
    logic        rdy, rsv, rpe, abt, fsr, breq, bid, ack, wv, wid;
    logic [31:0] rins, badr, wd;
    logic [2:0]  bcr, widx, lcr;
    int          bad_count = 0, check_count = 0, nreq = 0, lat = 0;

    always #50 clk = ~clk;
    always @(posedge clk) if (breq && ack) begin
        nreq <= nreq + 1;
        lcr <= bcr;
    end

    icache_fetch dut (
        .CLK(clk), .RSTN(rstn), .CACHE_EN(cen), .MMU_EN(mmu),
        .INV_ALL(inv), .UNLOCK_ALL(unl), .REQ_VALID(rv), .REQ_ADDR(ra),
        .REQ_CACHEABLE(rc), .REQ_LOCK(rl), .REQ_READY(rdy),
        .RSP_VALID(rsv), .RSP_INSTR(rins), .RSP_PERR(rpe),
        .EXEC_PERR(ep), .FSR_CLR(fc), .PREFETCH_ABORT(abt),
        .FSR_PERR(fsr), .BUS_REQ(breq), .BUS_ADDR(badr),
        .BUS_CRIT(bcr), .BUS_ID(bid), .BUS_ACK(ack), .BUS_RVALID(wv),
        .BUS_RID(wid), .BUS_RIDX(widx), .BUS_RDATA(wd)
    );
    mem_model mem (
        .clk(clk), .rstn(rstn), .gap(gap), .bus_req(breq),
        .bus_addr(badr), .bus_crit(bcr), .bus_id(bid), .ack(ack),
        .rvalid(wv), .rid(wid), .ridx(widx), .rdata(wd)
    );

    function automatic logic [31:0] ad(input int t, input int s);
        return {t[21:0], s[4:0], 5'h00};
    endfunction : ad

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize;
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // lock requests end at the allocation pulse, fetches at the answer
    task automatic fetch(input logic [31:0] a, input logic lk);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        ra = a;
        rl = lk;
        rv = 1'b1;
        @(negedge clk);
        rv = 1'b0;
        rl = 1'b0;
        lat = 1;
        while ((lk ? rdy : rsv) !== 1'b1 && lat < 300) begin
            @(negedge clk);
            lat++;
        end
    endtask : fetch

    task automatic go(input logic [31:0] a, input int nb);
        int n0;
        n0 = nreq;
        fetch(a, 1'b0);
        check(rins, ~{a[31:2], 2'b00});
        check(nreq - n0, nb);
        if (nb == 0) begin
            check(lat, 2);
            check(rpe, 1'b0);
        end
    endtask : go

    task automatic clr(input logic u);
        unl = u;
        @(negedge clk);
        unl = 1'b0;
        inv = 1'b1;
        @(negedge clk);
        inv = 1'b0;
        repeat (4) @(negedge clk);
    endtask : clr

    task automatic idle;
        repeat (30) @(negedge clk);
    endtask : idle

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize;
    end

    initial begin
        repeat (8) @(negedge clk);
        check(breq, 1'b0);
        check(rsv, 1'b0);
        rstn = 1'b1;
        gap = 4'h2;
        go(ad(1, 3) + 32'h14, 1);
        check(lcr, 3'h5);
        check(lat < 16, 1'b1);
        gap = 4'h0;
        idle;
        go(ad(1, 3), 0);
        go(ad(1, 3) + 32'h1c, 0);
        fetch(ad(2, 2), 1'b1);
        idle;
        clr(1'b0);
        go(ad(2, 2), 1);
        cen = 1'b1;
        go(ad(4, 6), 1);
        idle;
        mmu = 1'b1;
        go(ad(5, 6), 1);
        go(ad(6, 6), 1);
        go(ad(4, 6), 0);
        rc = 1'b1;
        go(ad(7, 6), 1);
        rc = 1'b0;
        go(ad(5, 6), 1);
        cen = 1'b0;
        go(ad(4, 6), 0);
        go(ad(7, 6), 0);
        cen = 1'b1;
        mmu = 1'b0;
        fetch(ad(15, 9), 1'b1);
        idle;
        clr(1'b0);
        go(ad(15, 9), 0);
        go(ad(5, 10), 1);
        idle;
        for (int k = 16; k < 49; k++) begin
            go(ad(k, 9), 1);
            idle;
        end
        go(ad(18, 9), 0);
        go(ad(15, 9), 0);
        go(ad(5, 10), 0);
        go(ad(16, 9), 1);
        idle;
        clr(1'b1);
        go(ad(15, 9), 1);
        ep = 1'b1;
        @(negedge clk);
        ep = 1'b0;
        check(abt, 1'b1);
        check(fsr, 1'b1);
        @(negedge clk);
        check(abt, 1'b0);
        fc = 1'b1;
        @(negedge clk);
        fc = 1'b0;
        check(fsr, 1'b0);
        summarize;
    end
endmodule : tb
